// ==== design/registered_bus_exchanger_12to24.sv ====
// Registered 12-bit to 24-bit bus exchanger with an APB register slave and a word FIFO.
// Assumes every pin input is asynchronous to pclk; the pad ring resolves the wires from
// the separate in, out and output-enable signals.
//
// Summary of operation
// - A B half loads A data at an edge only while its capture enable is low.
// - Enabling the halves on successive clocks assembles two A words into one wide word.
// - One shared register feeds the A outputs for transfers from B to A.
// - The half select picks which B half goes into the A register.
// - The A outputs come straight from a clocked register.
// - All control inputs are sampled into registers on the clock.
// - A port, low half and high half each have an active-low drive enable.
// - Drive state follows only sampled enables; reset forces them to the released state.
// - Low enables copy A into the low and high halves, the high half not while stream mode finds the FIFO full; both may load together.
// - Select high loads the low half, select low the high half, into A.
`default_nettype none
`include "exchanger_consts.svh"

module registered_bus_exchanger_12to24 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`HALF_WIDTH-1:0] a_port_in,
	output logic [`HALF_WIDTH-1:0] a_port_out,
	output logic a_port_oe,
	input wire logic [`HALF_WIDTH-1:0] b_low_half_in,
	output logic [`HALF_WIDTH-1:0] b_low_half_out,
	output logic b_low_half_oe,
	input wire logic [`HALF_WIDTH-1:0] b_high_half_in,
	output logic [`HALF_WIDTH-1:0] b_high_half_out,
	output logic b_high_half_oe,
	input wire logic low_half_capture_enable_n,
	input wire logic high_half_capture_enable_n,
	input wire logic half_select,
	input wire logic a_port_drive_enable_n,
	input wire logic low_half_drive_enable_n,
	input wire logic high_half_drive_enable_n
);

	localparam int LW = $clog2(`FIFO_DEPTH + 1);

	logic [`SYNC_WIDTH-1:0] pins_meta_q;
	logic [`SYNC_WIDTH-1:0] pins_q;
	logic [`SYNC_WIDTH-1:0] pins_raw;

	exchanger_pkg::half_t a_s;
	exchanger_pkg::half_t b_low_s;
	exchanger_pkg::half_t b_high_s;
	logic cap_low_n_s;
	logic cap_high_n_s;
	logic select_s;
	logic a_drive_n_s;
	logic low_drive_n_s;
	logic high_drive_n_s;

	exchanger_pkg::half_t b_low_q;
	exchanger_pkg::half_t b_high_q;
	exchanger_pkg::half_t a_reg_q;

	logic stream_en_q;
	logic drop_q;
	logic high_stall;
	logic high_load;

	logic fifo_in_valid;
	logic fifo_in_ready;
	exchanger_pkg::word_t fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	exchanger_pkg::word_t fifo_out_data;
	logic [LW-1:0] fifo_level;

	exchanger_pkg::reg_sel_t sel_w;
	logic setup;
	logic access;
	logic [31:0] rd_value;
	logic [31:0] prdata_q;
	logic err_q;
	logic pop_ok_q;

	// Both pin groups pass two flip-flops; the second stage doubles as the control register.
	assign pins_raw = {a_port_in, b_low_half_in, b_high_half_in,
		low_half_capture_enable_n, high_half_capture_enable_n, half_select,
		a_port_drive_enable_n, low_half_drive_enable_n, high_half_drive_enable_n};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pins_meta_q <= `SYNC_RESET;
			pins_q <= `SYNC_RESET;
		end
		else
		begin
			pins_meta_q <= pins_raw;
			pins_q <= pins_meta_q;
		end
	end

	assign a_s = pins_q[41:30];
	assign b_low_s = pins_q[29:18];
	assign b_high_s = pins_q[17:6];
	assign cap_low_n_s = pins_q[5];
	assign cap_high_n_s = pins_q[4];
	assign select_s = pins_q[3];
	assign a_drive_n_s = pins_q[2];
	assign low_drive_n_s = pins_q[1];
	assign high_drive_n_s = pins_q[0];

	// A full FIFO in stream mode holds off the high-half capture, so a word is never
	// overwritten before software has read it; the attempt is flagged instead.
	assign high_stall = stream_en_q & ~fifo_in_ready;
	assign high_load = ~cap_high_n_s & ~high_stall;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			b_low_q <= `HALF_RESET;
		end
		else if (!cap_low_n_s)
		begin
			b_low_q <= a_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			b_high_q <= `HALF_RESET;
		end
		else if (high_load)
		begin
			b_high_q <= a_s;
		end
	end

	// The single A-side register is shared by both halves and keeps its value while the
	// A port is released.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			a_reg_q <= `HALF_RESET;
		end
		else if (!a_drive_n_s)
		begin
			a_reg_q <= select_s ? b_low_s : b_high_s;
		end
	end

	assign a_port_out = a_reg_q;
	assign b_low_half_out = b_low_q;
	assign b_high_half_out = b_high_q;
	assign a_port_oe = ~a_drive_n_s;
	assign b_low_half_oe = ~low_drive_n_s;
	assign b_high_half_oe = ~high_drive_n_s;

	// The high-half capture completes a wide word; the low half taken in the same edge is
	// the new one.
	assign fifo_in_valid = stream_en_q & ~cap_high_n_s;
	assign fifo_in_data = {a_s, cap_low_n_s ? b_low_q : a_s};

	word_fifo #(
		.WIDTH(`WORD_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_word_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	assign sel_w = exchanger_pkg::decode_addr(paddr);
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = access;
	assign pslverr = access & err_q;
	assign prdata = prdata_q;

	// Popping only what was shown in the setup cycle keeps a word that arrives between
	// setup and access from being discarded unseen.
	assign fifo_out_ready = access & ~pwrite & (sel_w == exchanger_pkg::SEL_DATA) & pop_ok_q;

	always_comb
	begin
		rd_value = 32'h0000_0000;
		unique case (sel_w)
			exchanger_pkg::SEL_CTRL:
			begin
				rd_value[`CTRL_STREAM_BIT] = stream_en_q;
			end
			exchanger_pkg::SEL_STATUS:
			begin
				rd_value[`STAT_EMPTY_BIT] = ~fifo_out_valid;
				rd_value[`STAT_FULL_BIT] = ~fifo_in_ready;
				rd_value[`STAT_DROP_BIT] = drop_q;
				rd_value[`STAT_A_DRIVE_BIT] = a_port_oe;
				rd_value[`STAT_LOW_DRIVE_BIT] = b_low_half_oe;
				rd_value[`STAT_HIGH_DRIVE_BIT] = b_high_half_oe;
				rd_value[`STAT_LEVEL_LSB +: LW] = fifo_level;
			end
			exchanger_pkg::SEL_DATA:
			begin
				rd_value[`DATA_VALID_BIT] = fifo_out_valid;
				rd_value[`WORD_WIDTH-1:0] = fifo_out_valid ? fifo_out_data : '0;
			end
			exchanger_pkg::SEL_HALVES:
			begin
				rd_value[`WORD_WIDTH-1:0] = {b_high_q, b_low_q};
			end
			exchanger_pkg::SEL_AREG:
			begin
				rd_value[`HALF_WIDTH-1:0] = a_reg_q;
			end
			exchanger_pkg::SEL_NONE:
			begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			pop_ok_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_value;
			err_q <= (sel_w == exchanger_pkg::SEL_NONE);
			pop_ok_q <= fifo_out_valid;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stream_en_q <= `CTRL_RESET;
		end
		else if (access && pwrite && pstrb[0] && sel_w == exchanger_pkg::SEL_CTRL)
		begin
			stream_en_q <= pwdata[`CTRL_STREAM_BIT];
		end
	end

	// A stalled capture in the clearing cycle keeps the flag set.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drop_q <= 1'b0;
		end
		else if (fifo_in_valid && !fifo_in_ready)
		begin
			drop_q <= 1'b1;
		end
		else if (access && pwrite && pstrb[0] && sel_w == exchanger_pkg::SEL_STATUS
			&& pwdata[`STAT_DROP_BIT])
		begin
			drop_q <= 1'b0;
		end
	end

endmodule : registered_bus_exchanger_12to24

`default_nettype wire

// ==== design/exchanger_consts.svh ====
// Constants of the registered 12-to-24 bus exchanger: register offsets, field positions,
// reset values and sizes.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef EXCHANGER_CONSTS_SVH
`define EXCHANGER_CONSTS_SVH

`define HALF_WIDTH 12
`define WORD_WIDTH 24
`define FIFO_DEPTH 16

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08
`define REG_HALVES 8'h0c
`define REG_AREG 8'h10

`define CTRL_STREAM_BIT 0
`define CTRL_RESET 1'h0

`define STAT_EMPTY_BIT 0
`define STAT_FULL_BIT 1
`define STAT_DROP_BIT 2
`define STAT_A_DRIVE_BIT 3
`define STAT_LOW_DRIVE_BIT 4
`define STAT_HIGH_DRIVE_BIT 5
`define STAT_LEVEL_LSB 8

`define DATA_VALID_BIT 31

`define SYNC_WIDTH 42
`define SYNC_RESET 42'h000_0000_0037
`define HALF_RESET 12'h000

`endif

// ==== design/exchanger_pkg.sv ====
// Types and address decode shared by the exchanger design files.
// Assumes exchanger_consts.svh on the include path.
`default_nettype none
`include "exchanger_consts.svh"

package exchanger_pkg;

	typedef logic [`HALF_WIDTH-1:0] half_t;
	typedef logic [`WORD_WIDTH-1:0] word_t;

	typedef enum logic [2:0] {
		SEL_CTRL,
		SEL_STATUS,
		SEL_DATA,
		SEL_HALVES,
		SEL_AREG,
		SEL_NONE
	} reg_sel_t;

	function automatic reg_sel_t decode_addr(input logic [7:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		case (addr)
			`REG_CTRL: sel = SEL_CTRL;
			`REG_STATUS: sel = SEL_STATUS;
			`REG_DATA: sel = SEL_DATA;
			`REG_HALVES: sel = SEL_HALVES;
			`REG_AREG: sel = SEL_AREG;
			default: sel = SEL_NONE;
		endcase
		return sel;
	endfunction : decode_addr

endpackage : exchanger_pkg

`default_nettype wire

// ==== design/word_fifo.sv ====
// Word FIFO with valid and ready on both sides and a registered output stage.
// Assumes a single clock and an asynchronous active-low reset.
`default_nettype none

module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);

	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [LW-1:0] count_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic push;
	logic take;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] ptr);
		return (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
	endfunction : next_ptr

	// The output stage counts toward the level, so full means DEPTH words in total.
	assign level = count_q + LW'(out_valid_q);
	assign in_ready = (level < LW'(DEPTH));
	assign push = in_valid & in_ready;
	assign take = (count_q != '0) & (~out_valid_q | out_ready);
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= next_ptr(wr_ptr_q);
			end
			if (take)
			begin
				rd_ptr_q <= next_ptr(rd_ptr_q);
			end
			count_q <= count_q + LW'(push) - LW'(take);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end
		else if (take)
		begin
			out_valid_q <= 1'b1;
			out_data_q <= mem_q[rd_ptr_q];
		end
		else if (out_ready)
		begin
			out_valid_q <= 1'b0;
		end
	end

endmodule : word_fifo

`default_nettype wire

// ==== test/exchanger_monitor.sv ====
// Checker for the exchanger's pin timing and APB answers.
// Assumes binding to the top module; pin inputs pass two sync flops first.
`default_nettype none
`include "exchanger_consts.svh"

module exchanger_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [`HALF_WIDTH-1:0] a_port_in,
	input wire logic [`HALF_WIDTH-1:0] a_port_out,
	input wire logic a_port_oe,
	input wire logic [`HALF_WIDTH-1:0] b_low_half_in,
	input wire logic [`HALF_WIDTH-1:0] b_low_half_out,
	input wire logic b_low_half_oe,
	input wire logic [`HALF_WIDTH-1:0] b_high_half_in,
	input wire logic [`HALF_WIDTH-1:0] b_high_half_out,
	input wire logic b_high_half_oe,
	input wire logic low_half_capture_enable_n,
	input wire logic high_half_capture_enable_n,
	input wire logic half_select,
	input wire logic a_port_drive_enable_n,
	input wire logic low_half_drive_enable_n,
	input wire logic high_half_drive_enable_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] up_q;
	// Pin checks look up to three edges back, so they wait until that history is post-reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			up_q <= 3'h0;
		else if (up_q != 3'h4)
			up_q <= up_q + 3'h1;
	end
	wire live = up_q == 3'h4;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_a_drive: assert property (live |-> a_port_oe == !$past(a_port_drive_enable_n, 2))
		else $error("A drive state wrong");
	a_low_drive: assert property (live |-> b_low_half_oe == !$past(low_half_drive_enable_n, 2))
		else $error("low half drive state wrong");
	a_high_drive: assert property (live |->
		b_high_half_oe == !$past(high_half_drive_enable_n, 2)) else $error("high drive wrong");
	a_low_load: assert property (live && !$past(low_half_capture_enable_n, 3) |->
		b_low_half_out == $past(a_port_in, 3)) else $error("low half load wrong");
	a_high_hold: assert property (live && $past(high_half_capture_enable_n, 3) |->
		$stable(b_high_half_out)) else $error("high half changed unasked");
	a_areg_load: assert property (live && !$past(a_port_drive_enable_n, 3) |->
		a_port_out == ($past(half_select, 3) ? $past(b_low_half_in, 3) :
		$past(b_high_half_in, 3))) else $error("A register load wrong");
	a_ready_access: assert property (pready == (psel && penable))
		else $error("pready outside access");
	a_unmapped_err: assert property (psel && penable && !(paddr inside {`REG_CTRL, `REG_STATUS,
		`REG_DATA, `REG_HALVES, `REG_AREG}) |-> pslverr) else $error("no error on unmapped");
endmodule : exchanger_monitor

bind registered_bus_exchanger_12to24 exchanger_monitor mon_u (.*);

`default_nettype wire

// ==== test/exchanger_far_end.sv ====
// Far side: processor on the A wire, synchronous memory on the B halves.
// Assumes each wire is driven by the far side only while the exchanger releases it.
`default_nettype none
`include "exchanger_consts.svh"

module exchanger_far_end (
	input wire logic a_oe,
	input wire logic lo_oe,
	input wire logic hi_oe,
	input wire logic [`HALF_WIDTH-1:0] a_dut,
	input wire logic [`HALF_WIDTH-1:0] lo_dut,
	input wire logic [`HALF_WIDTH-1:0] hi_dut,
	input wire logic [`HALF_WIDTH-1:0] cpu_a,
	input wire logic [`HALF_WIDTH-1:0] mem_lo,
	input wire logic [`HALF_WIDTH-1:0] mem_hi,
	output logic [`HALF_WIDTH-1:0] a_wire,
	output logic [`HALF_WIDTH-1:0] lo_wire,
	output logic [`HALF_WIDTH-1:0] hi_wire
);
	timeunit 1ns;
	timeprecision 100ps;
	// Stepping back on a driven wire avoids contention that the pads would not resolve.
	assign a_wire = a_oe ? a_dut : cpu_a;
	assign lo_wire = lo_oe ? lo_dut : mem_lo;
	assign hi_wire = hi_oe ? hi_dut : mem_hi;
endmodule : exchanger_far_end

`default_nettype wire

// ==== test/registered_bus_exchanger_12to24_tb_top.sv ====
// Bench for the exchanger: APB tasks, pin stimulus and self-checks.
// Assumes the far-side model and the bound checker beside the design.
`default_nettype none
`include "exchanger_consts.svh"

module registered_bus_exchanger_12to24_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr, a_oe, lo_oe, hi_oe;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	exchanger_pkg::half_t a_in, lo_in, hi_in, a_out, lo_out, hi_out;
	exchanger_pkg::half_t cpu_a = 12'h000, mem_lo = 12'h000, mem_hi = 12'h000;
	logic lo_cap_n = 1'b1, hi_cap_n = 1'b1, sel = 1'b0, a_en_n = 1'b1, lo_en_n = 1'b1;
	logic hi_en_n = 1'b1;
	int error_cnt = 0, tests_run = 0;
	always #5 pclk = ~pclk;
	registered_bus_exchanger_12to24 dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .a_port_in(a_in),
		.a_port_out(a_out), .a_port_oe(a_oe), .b_low_half_in(lo_in), .b_low_half_out(lo_out),
		.b_low_half_oe(lo_oe), .b_high_half_in(hi_in), .b_high_half_out(hi_out),
		.b_high_half_oe(hi_oe), .low_half_capture_enable_n(lo_cap_n),
		.high_half_capture_enable_n(hi_cap_n), .half_select(sel),
		.a_port_drive_enable_n(a_en_n), .low_half_drive_enable_n(lo_en_n),
		.high_half_drive_enable_n(hi_en_n));
	exchanger_far_end far_u (.a_oe(a_oe), .lo_oe(lo_oe), .hi_oe(hi_oe), .a_dut(a_out),
		.lo_dut(lo_out), .hi_dut(hi_out), .cpu_a(cpu_a), .mem_lo(mem_lo), .mem_hi(mem_hi),
		.a_wire(a_in), .lo_wire(lo_in), .hi_wire(hi_in));
	task automatic close_out;
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(rd & mask, exp);
	endtask : rchk
	task automatic cap(input logic l, input logic h, input exchanger_pkg::half_t v);
		@(posedge pclk);
		lo_cap_n <= l;
		hi_cap_n <= h;
		cpu_a <= v;
	endtask : cap
	task automatic wt;
		repeat (5) @(posedge pclk);
	endtask : wt
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		wt();
		chk(32'({a_oe, lo_oe, hi_oe}), 32'h0);
		rchk(`REG_STATUS, 32'h1f3f, 32'h1);
		@(posedge pclk);
		lo_en_n <= 1'b0;
		hi_en_n <= 1'b0;
		wt();
		chk(32'({a_oe, lo_oe, hi_oe}), 32'h3);
		cap(1'b0, 1'b1, 12'h5a1);
		cap(1'b1, 1'b0, 12'h3c2);
		cap(1'b1, 1'b1, 12'hfff);
		wt();
		rchk(`REG_HALVES, 32'hffffff, 32'h3c25a1);
		cap(1'b0, 1'b0, 12'h7e4);
		cap(1'b1, 1'b1, 12'h001);
		wt();
		chk(32'(hi_out), 32'h7e4);
		apb(1'b1, `REG_CTRL, 32'h1);
		rchk(`REG_CTRL, 32'h1, 32'h1);
		// Seventeen words into sixteen places: the last high half must be refused.
		for (int i = 0; i < 17; i++)
		begin
			cap(1'b0, 1'b1, 12'h100 + 12'(i));
			cap(1'b1, 1'b0, 12'ha00 + 12'(i));
		end
		cap(1'b1, 1'b1, 12'h000);
		wt();
		rchk(`REG_STATUS, 32'h1f3f, 32'h1036);
		rchk(`REG_HALVES, 32'hffffff, 32'ha0f110);
		for (int i = 0; i < 16; i++)
		begin
			rchk(`REG_DATA, 32'hffffffff, {8'h80, 12'ha00 + 12'(i), 12'h100 + 12'(i)});
			@(posedge pclk);
		end
		rchk(`REG_DATA, 32'h80000000, 32'h0);
		rchk(`REG_STATUS, 32'h1f07, 32'h5);
		apb(1'b1, `REG_STATUS, 32'h4);
		rchk(`REG_STATUS, 32'h1f07, 32'h1);
		rchk(8'h20, 32'hffffffff, 32'h0);
		chk(32'(err), 32'h1);
		@(posedge pclk);
		lo_en_n <= 1'b1;
		hi_en_n <= 1'b1;
		a_en_n <= 1'b0;
		sel <= 1'b1;
		mem_lo <= 12'h9b3;
		mem_hi <= 12'h46c;
		// The low half stays driven until its release passes the pin flops, so the memory
		// value needs a few more edges to reach the A register.
		wt();
		wt();
		chk(32'(a_out), 32'h9b3);
		@(posedge pclk);
		sel <= 1'b0;
		wt();
		rchk(`REG_AREG, 32'hfff, 32'h46c);
		@(posedge pclk);
		a_en_n <= 1'b1;
		mem_hi <= 12'h111;
		wt();
		chk(32'({a_oe, lo_oe, hi_oe}), 32'h0);
		rchk(`REG_AREG, 32'hfff, 32'h46c);
		close_out();
	end
	initial
	begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		close_out();
	end
endmodule : registered_bus_exchanger_12to24_tb_top

`default_nettype wire
